// ===== odsc_pkg.sv
/*
 package of the opcode decode and state count block: opcode fields,
 instruction classes, cycle-type state costs and the decode result struct.
 assumes a single cpu clock and the cpu reset.
*/
// Behaviour
// - the opcode that picks the class is bits 15 to 8 of the first word.
// - a shared map cell picks its first instruction when bit 7 is 0, else the second.
// - push and pop have no codes of their own and decode as register-memory moves.
// - execution states, except for the block copy, are the sum over six cycle types of count times state cost.
// - fetch from on-chip rom and byte access to on-chip ram cost 2 states each.
// - branch-address read from rom and stack access to ram cost 2 states each.
// - an internal cycle costs 1 state; a peripheral byte access costs 2 or 3.
// - the block copy takes 4n + 9 states, n being the low byte of the count register.
package odsc_pkg;
   localparam int OP_HI = 15;
   localparam int OP_LO = 8;
   localparam int SEL_BIT = 7;
   localparam logic [2:0] COST_MEM = 3'h2;
   localparam logic [2:0] COST_INT = 3'h1;
   localparam logic [2:0] COST_PER_FAST = 3'h2;
   localparam logic [2:0] COST_PER_SLOW = 3'h3;
   localparam logic [3:0] CPY_BASE = 4'h9;
   localparam int CPY_SHIFT = 2;
   localparam int CW = 4;
   localparam int SW = 12;
   localparam logic [7:0] OPC_CPY = 8'h7b;
   localparam logic [7:0] OPC_CALL_IND = 8'h5f;
   localparam logic [7:0] OPC_CALL_ABS = 8'h5e;
   localparam logic [7:0] OPC_CALL_REG = 8'h5d;
   localparam logic [7:0] OPC_BIT_SET_OP_RD = 8'h7d;
   localparam logic [7:0] OPC_BIT_SET_OP_AA = 8'h7f;
   localparam logic [3:0] NIB_BRANCH = 4'h4;
   localparam logic [3:0] NIB_MOVIMM = 4'hf;
   localparam logic [7:0] OPC_MOVIND = 8'h6d;
   localparam logic [7:0] OPC_NOP = 8'h00;
   typedef enum logic [2:0] {
      ODSC_CLS_ALU, ODSC_CLS_MOVE, ODSC_CLS_BRANCH, ODSC_CLS_CALL,
      ODSC_CLS_BIT, ODSC_CLS_COPY, ODSC_CLS_CTRL
   } odsc_cls_t;
   typedef struct packed {
      logic [CW-1:0] fetch;
      logic [CW-1:0] brRead;
      logic [CW-1:0] stack;
      logic [CW-1:0] byteAcc;
      logic [CW-1:0] wordAcc;
      logic [CW-1:0] internal;
   } odsc_counts_t;
   typedef struct packed {
      odsc_cls_t cls;
      logic second;
      logic [7:0] opcode;
   } odsc_dec_t;
endpackage : odsc_pkg

// ===== odsc_decode.sv
/*
 opcode decoder and state counter; result registered one cycle after valid.
 assumes the fetch unit presents whole first words and the count register low
 byte, and that the sequencer reports peripheral slowness per byte access.
*/
`timescale 1ns/100ps
module odsc_decode
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic instValid,
   input wire logic [15:0] instWord,
   input wire logic [7:0] copyCountLowByte,
   input wire logic byteToPeriph,
   input wire logic periphSlow,
   output odsc_pkg::odsc_dec_t decOut,
   output odsc_pkg::odsc_counts_t countsOut,
   output logic [odsc_pkg::SW-1:0] statesOut,
   output logic decValid
);
   import odsc_pkg::*;
   odsc_dec_t dec, next_dec;
   odsc_counts_t cnt, next_cnt;
   logic [SW-1:0] states, next_states;
   logic valid, next_valid;
   logic [7:0] opc;
   logic [2:0] costL;
   assign decOut = dec;
   assign countsOut = cnt;
   assign statesOut = states;
   assign decValid = valid;

   // constants must fit the fields that use them
   if (SW < 11)
   begin : g_sw_check
      $error("state width cannot hold the longest block copy");
   end
   if (OP_HI - OP_LO != 7)
   begin : g_op_check
      $error("opcode field must be one byte");
   end
   if (CW < 2)
   begin : g_cw_check
      $error("cycle count width too narrow");
   end
   if (SEL_BIT >= OP_LO)
   begin : g_sel_check
      $error("select bit must lie in the second byte");
   end

   always_comb
   begin
      opc = instWord[OP_HI:OP_LO];
      next_valid = instValid;
      next_dec = '{cls: ODSC_CLS_ALU, second: instWord[SEL_BIT],
         opcode: opc};
      next_cnt = '{fetch: CW'(1), default: '0};
      if (opc[7:4] == NIB_BRANCH)
      begin
         next_dec.cls = ODSC_CLS_BRANCH;
         next_cnt.fetch = CW'(2);
      end
      else if (opc == OPC_CALL_IND)
      begin
         next_dec.cls = ODSC_CLS_CALL;
         next_cnt.fetch = CW'(2);
         next_cnt.brRead = CW'(1);
         next_cnt.stack = CW'(1);
      end
      else if (opc == OPC_CALL_ABS || opc == OPC_CALL_REG)
      begin
         next_dec.cls = ODSC_CLS_CALL;
         next_cnt.fetch = (opc == OPC_CALL_ABS) ? CW'(2) : CW'(1);
         next_cnt.stack = CW'(1);
         next_cnt.internal = (opc == OPC_CALL_ABS) ? CW'(2) : CW'(0);
      end
      else if (opc == OPC_CPY)
      begin
         next_dec.cls = ODSC_CLS_COPY;
         next_cnt.fetch = CW'(2);
      end
      else if (opc == OPC_BIT_SET_OP_RD || opc == OPC_BIT_SET_OP_AA)
      begin
         next_dec.cls = ODSC_CLS_BIT;
         next_cnt.fetch = CW'(2);
         next_cnt.byteAcc = CW'(2);
      end
      else if (opc == OPC_MOVIND || opc[7:4] == NIB_MOVIMM)
      begin
         // push and pop arrive here as ordinary indirect moves
         next_dec.cls = ODSC_CLS_MOVE;
         next_cnt.wordAcc = (opc == OPC_MOVIND) ? CW'(1) : CW'(0);
         next_cnt.internal = (opc == OPC_MOVIND) ? CW'(2) : CW'(0);
      end
      else if (opc == OPC_NOP)
         next_dec.cls = ODSC_CLS_CTRL;
      costL = byteToPeriph ? (periphSlow ? COST_PER_SLOW : COST_PER_FAST)
                           : COST_MEM;
      if (next_dec.cls == ODSC_CLS_COPY)
         next_states = SW'({copyCountLowByte, 2'h0}) + SW'(CPY_BASE);
      else
         next_states = SW'(next_cnt.fetch) * SW'(COST_MEM)
            + SW'(next_cnt.brRead) * SW'(COST_MEM)
            + SW'(next_cnt.stack) * SW'(COST_MEM)
            + SW'(next_cnt.byteAcc) * SW'(costL)
            + SW'(next_cnt.wordAcc) * SW'(COST_MEM)
            + SW'(next_cnt.internal) * SW'(COST_INT);
   end
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dec <= '{cls: ODSC_CLS_CTRL, second: 1'b0, opcode: 8'h00};
         cnt <= '0;
         states <= '0;
         valid <= 1'b0;
      end
      else if (clkEn)
      begin
         dec <= next_dec;
         cnt <= next_cnt;
         states <= next_states;
         valid <= next_valid;
      end
   end
   AST_OPC: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid |=> decOut.opcode == $past(instWord[15:8]))
      else $error("opcode not taken from high byte");
   AST_SEL: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid |=> decOut.second == $past(instWord[7]))
      else $error("pair select not bit 7");
   AST_CPY: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[15:8] == 8'h7b |=>
      statesOut == 12'(4 * $past(copyCountLowByte) + 9))
      else $error("block copy state count wrong");
   AST_BIT_SET_OP: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[15:8] == 8'h7f && !byteToPeriph |=>
      statesOut == 12'h008)
      else $error("bit set example not 8 states");
   AST_CALL: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[15:8] == 8'h5f |=> statesOut == 12'h008)
      else $error("indirect call not 8 states");
   AST_PER: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[15:8] == 8'h7d && byteToPeriph
      && periphSlow |=> statesOut == 12'h00a)
      else $error("slow peripheral access cost wrong");
   AST_MOVE: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[15:8] == 8'h6d |=>
      decOut.cls == ODSC_CLS_MOVE && statesOut == 12'h006)
      else $error("stack move not decoded as move");
   AST_SUM: assert property (@(posedge mclk) disable iff (!arst_n)
      decValid && decOut.cls == ODSC_CLS_BRANCH |->
      statesOut == 12'(2 * countsOut.fetch))
      else $error("state sum mismatch");
   AST_HOLD: assert property (@(posedge mclk) disable iff (!arst_n)
      !clkEn |=> $stable(countsOut) && $stable(statesOut))
      else $error("counts moved while frozen");

   AST_VALID: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn |=>
      decValid == $past(instValid))
      else $error("valid not a registered copy");

   AST_BRANCH: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_HI-3] == NIB_BRANCH |=>
      decOut.cls == ODSC_CLS_BRANCH && countsOut.fetch == CW'(2)
      && statesOut == 12'h004)
      else $error("branch not two fetches");

   AST_CALLABS: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_LO] == OPC_CALL_ABS |=>
      countsOut.stack == CW'(1) && countsOut.internal == CW'(2)
      && statesOut == 12'h008)
      else $error("absolute call state count wrong");

   AST_CALLREG: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_LO] == OPC_CALL_REG |=>
      decOut.cls == ODSC_CLS_CALL && countsOut.stack == CW'(1)
      && statesOut == 12'h004)
      else $error("register call state count wrong");

   AST_CALLJ: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_LO] == OPC_CALL_IND |=>
      countsOut.fetch == CW'(2) && countsOut.brRead == CW'(1)
      && countsOut.stack == CW'(1))
      else $error("indirect call cycle counts wrong");

   AST_NOP: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_LO] == OPC_NOP |=>
      decOut.cls == ODSC_CLS_CTRL && countsOut.fetch == CW'(1)
      && statesOut == 12'h002)
      else $error("no-operation not one fetch");

   AST_MOVIMM: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_HI-3] == NIB_MOVIMM |=>
      decOut.cls == ODSC_CLS_MOVE && countsOut.wordAcc == CW'(0)
      && statesOut == 12'h002)
      else $error("immediate move decode wrong");

   AST_PUSH: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_LO] == OPC_MOVIND |=>
      countsOut.wordAcc == CW'(1) && countsOut.internal == CW'(2)
      && countsOut.stack == CW'(0))
      else $error("stack move counted apart from move");

   AST_FAST: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_LO] == OPC_BIT_SET_OP_RD
      && byteToPeriph && !periphSlow |=>
      statesOut == 12'h008)
      else $error("fast peripheral access cost wrong");

   AST_BITMEM: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_LO] == OPC_BIT_SET_OP_RD
      && !byteToPeriph |=>
      countsOut.byteAcc == CW'(2) && statesOut == 12'h008)
      else $error("bit operation on memory not 8 states");

   AST_CPYCNT: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_LO] == OPC_CPY |=>
      decOut.cls == ODSC_CLS_COPY && countsOut.fetch == CW'(2)
      && decOut.second == $past(instWord[SEL_BIT]))
      else $error("block copy decode wrong");

   AST_ALU: assert property (@(posedge mclk) disable iff (!arst_n)
      clkEn && instValid && instWord[OP_HI:OP_HI-3] == 4'h8 |=>
      decOut.cls == ODSC_CLS_ALU && countsOut.fetch == CW'(1)
      && statesOut == 12'h002)
      else $error("alu class decode wrong");
endmodule : odsc_decode

// ===== odsc_mem_model.sv
/*
 far-side model: maps a byte address to memory or a peripheral.
 assumes addr is stable from the bench each cycle.
*/
`timescale 1ns/100ps
module odsc_mem_model
(
   input wire logic [7:0] addr,
   output logic byteToPeriph,
   output logic periphSlow
);
   // top page holds peripherals; odd modules are slow
   assign byteToPeriph = (addr[7:4] == 4'hf);
   assign periphSlow = byteToPeriph & addr[0];
endmodule : odsc_mem_model

// ===== opcode_decode_state_count_test.sv
/*
 self-checking bench of odsc_decode with random words.
 assumes odsc_pkg and odsc_mem_model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module opcode_decode_state_count_test;
   import odsc_pkg::*;
   logic mclk = 0, arst_n = 0, clkEn = 0, instValid = 0;
   logic [15:0] instWord = 16'h0000;
   logic [7:0] copyCountLowByte = 8'h00, addr = 8'h00;
   logic byteToPeriph, periphSlow, decValid;
   logic [SW-1:0] statesOut;
   logic [31:0] lfsr = 32'h01f2;
   odsc_dec_t decOut;
   odsc_counts_t countsOut;
   int num_errors = 0, num_checks = 0;
   always #50 mclk = ~mclk;
   odsc_mem_model mem (.addr(addr), .byteToPeriph(byteToPeriph),
      .periphSlow(periphSlow));
   odsc_decode dut (.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn),
      .instValid(instValid), .instWord(instWord),
      .copyCountLowByte(copyCountLowByte), .byteToPeriph(byteToPeriph),
      .periphSlow(periphSlow), .decOut(decOut), .countsOut(countsOut),
      .statesOut(statesOut), .decValid(decValid));
   function automatic odsc_cls_t exp_cls(input logic [7:0] op);
      casez (op)
         8'h4?: return ODSC_CLS_BRANCH;
         8'h5d, 8'h5e, 8'h5f: return ODSC_CLS_CALL;
         8'h7b: return ODSC_CLS_COPY;
         8'h7d, 8'h7f: return ODSC_CLS_BIT;
         8'h6d, 8'hf?: return ODSC_CLS_MOVE;
         8'h00: return ODSC_CLS_CTRL;
         default: return ODSC_CLS_ALU;
      endcase
   endfunction : exp_cls
   function automatic int exp_states(input logic [7:0] op, input int n,
      input int cost);
      casez (op)
         8'h4?, 8'h5d: return 4;
         8'h5e, 8'h5f: return 8;
         8'h7b: return 4 * n + 9;
         8'h7d, 8'h7f: return 4 + 2 * cost;
         8'h6d: return 6;
         8'hf?, 8'h00: return 2;
         default: return 2;
      endcase
   endfunction : exp_states
   task automatic run_one(input logic [15:0] w, input logic [7:0] n,
      input logic [7:0] a);
      int st;
      @(posedge mclk);
      instWord <= w;
      copyCountLowByte <= n;
      addr <= a;
      instValid <= 1'b1;
      clkEn <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      st = exp_states(w[15:8], n, (a[7:4] == 4'hf && a[0]) ? 3 : 2);
      `CHK("valid", 1'b1, decValid)
      `CHK("opcode", w[15:8], decOut.opcode)
      `CHK("second", w[7], decOut.second)
      `CHK("class", exp_cls(w[15:8]), decOut.cls)
      `CHK("states", SW'(st), statesOut)
      if (w[15:8] == 8'h5f) `CHK("branch reads", 4'h1, countsOut.brRead)
   endtask : run_one
   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      #2000000;
      num_errors++;
      print_verdict;
   end
   initial
   begin
      logic [SW-1:0] held;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      run_one(16'h7f00, 8'h00, 8'h10);
      run_one(16'h7d80, 8'h00, 8'hf1);
      run_one(16'h7d00, 8'h00, 8'hf0);
      run_one(16'h5f10, 8'h00, 8'h00);
      run_one(16'h5e00, 8'h00, 8'h00);
      run_one(16'h5d80, 8'h00, 8'h00);
      run_one(16'h4f00, 8'h00, 8'h00);
      run_one(16'h7b5c, 8'h00, 8'h00);
      run_one(16'h7b5c, 8'hff, 8'h00);
      run_one(16'h6df0, 8'h00, 8'h00);
      run_one(16'hf012, 8'h00, 8'h00);
      run_one(16'h0000, 8'h00, 8'h00);
      held = statesOut;
      @(posedge mclk);
      clkEn <= 1'b0;
      instValid <= 1'b0;
      instWord <= 16'h7b00;
      copyCountLowByte <= 8'h20;
      @(posedge mclk);
      @(negedge mclk);
      `CHK("frozen states", held, statesOut)
      `CHK("frozen valid", 1'b1, decValid)
      repeat (200)
      begin
         lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
         run_one(lfsr[15:0], lfsr[23:16], lfsr[31:24]);
      end
      @(posedge mclk);
      arst_n <= 1'b0;
      @(negedge mclk);
      `CHK("reset valid", 1'b0, decValid)
      `CHK("reset states", SW'(0), statesOut)
      `CHK("reset class", ODSC_CLS_CTRL, decOut.cls)
      @(posedge mclk);
      arst_n <= 1'b1;
      run_one(16'h7f00, 8'h00, 8'h10);
      print_verdict;
   end
endmodule : opcode_decode_state_count_test
